// >>> hw/sbt_pkg.sv
// Overview of operation
// - WRITE after read only once the burst ended or after burst terminate
// - READ after write only once the burst ended or after burst terminate
// - RESET from power-on with all banks idle starts resetting
// - transitions need clock enable high on both edges; wait tXP/tXSR
// - never send a state and command pair that is not listed
// - no command to a bank in precharge, activate or auto-precharge burst
// - only NOPs during refresh, MR read, MR write and precharge-all
// - precharge-all lasts tRP, needs every bank in a prechargeable state
// - precharge to an idle bank still needs tRP
// - only NOPs to a bank in an auto-precharge burst
// - other banks take commands their own state permits
package sbt_pkg;
   localparam int CLK_PS     = 10000;
   localparam int T_RCD_NS   = 18;
   localparam int T_RP_NS    = 18;
   localparam int T_RFCPB_NS = 90;
   localparam int T_RFCAB_NS = 130;
   localparam int T_MRR_NS   = 20;
   localparam int T_MRW_NS   = 50;
   localparam int T_INIT_NS  = 200000;
   localparam int RCD_CYC    = (T_RCD_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int RP_CYC     = (T_RP_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int RFCPB_CYC  = (T_RFCPB_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int RFCAB_CYC  = (T_RFCAB_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int MRR_CYC    = (T_MRR_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int MRW_CYC    = (T_MRW_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int INIT_CYC   = (T_INIT_NS * 1000 + CLK_PS - 1) / CLK_PS;

   typedef enum logic [3:0] {
      OP_NOP = 4'h0, OP_ACT = 4'h1, OP_RD = 4'h2, OP_WR = 4'h3,
      OP_PRE = 4'h4, OP_PREA = 4'h5, OP_REFPB = 4'h6, OP_REFAB = 4'h7,
      OP_MRR = 4'h8, OP_MRW = 4'h9, OP_RESET = 4'hA, OP_BST = 4'hB
   } sbt_op_e;

   typedef enum logic [3:0] {
      BS_IDLE = 4'h0, BS_ACTIVATING = 4'h1, BS_ACTIVE = 4'h3, BS_READING = 4'h2,
      BS_WRITING = 4'h6, BS_RDAP = 4'h7, BS_WRAP = 4'h5, BS_PRECHARGING = 4'h4,
      BS_REFRESHING = 4'hC
   } sbt_bank_e;

   typedef enum logic [1:0] {
      DEV_POWERON = 2'h0, DEV_RESETTING = 2'h1, DEV_RUN = 2'h3, DEV_BUSY = 2'h2
   } sbt_dev_e;
endpackage

// >>> hw/sbt_host.sv
`timescale 1ns/100ps
`default_nettype none
module sbt_host import sbt_pkg::*; #(
   parameter int NB       = 8,
   parameter int BURST    = 4,
   parameter int TW       = 16,
   parameter int INIT_CYC_P = INIT_CYC
) (
   input  wire logic             clk_sys,
   input  wire logic             arst_n,
   input  wire logic             reqValid,
   input  wire sbt_op_e          reqOp,
   input  wire logic [$clog2(NB)-1:0] reqBank,
   input  wire logic             reqAp,
   output logic                  reqReady,
   output logic                  memCke,
   output sbt_op_e               memCmd,
   output logic [$clog2(NB)-1:0] memBank,
   output logic                  memAp,
   output sbt_dev_e              devState
);
   localparam int BW = $clog2(NB);
   localparam int A_RCD = RCD_CYC;
   localparam int A_RP = RP_CYC;
   localparam int A_MRW = MRW_CYC;
   localparam logic [TW-1:0] LD_RCD   = TW'(RCD_CYC - 1);
   localparam logic [TW-1:0] LD_RP    = TW'(RP_CYC - 1);
   localparam logic [TW-1:0] LD_BURST = TW'(BURST - 1);
   localparam logic [TW-1:0] LD_APB   = TW'(BURST + RP_CYC - 1);
   localparam logic [TW-1:0] LD_RFCPB = TW'(RFCPB_CYC - 1);
   localparam logic [TW-1:0] LD_RFCAB = TW'(RFCAB_CYC - 1);
   localparam logic [TW-1:0] LD_MRR   = TW'(MRR_CYC - 1);
   localparam logic [TW-1:0] LD_MRW   = TW'(MRW_CYC - 1);
   localparam logic [TW-1:0] LD_INIT  = TW'(INIT_CYC_P - 1);

   // where a timed state settles once its timer has run out
   function automatic sbt_bank_e settle(input sbt_bank_e s);
      case (s)
         BS_ACTIVATING, BS_READING, BS_WRITING: settle = BS_ACTIVE;
         BS_RDAP, BS_WRAP, BS_PRECHARGING, BS_REFRESHING: settle = BS_IDLE;
         default: settle = s;
      endcase
   endfunction

   sbt_bank_e       bankState_q [NB];
   logic [TW-1:0]   bankTimer_q [NB];
   sbt_bank_e       bankState_d [NB];
   logic [TW-1:0]   bankTimer_d [NB];
   logic [NB-1:0]   bIdle;
   logic [NB-1:0]   bIdleAct;
   logic [NB-1:0]   bRef;
   logic [BW-1:0]   lastBank_q;
   sbt_dev_e        devState_q;
   sbt_dev_e        devState_d;
   logic [TW-1:0]   devTimer_q;
   logic [TW-1:0]   devTimer_d;
   logic            devClr_q;
   logic            devClr_d;
   logic            memCke_q;
   sbt_op_e         memCmd_q;
   logic [BW-1:0]   memBank_q;
   logic            memAp_q;

   // ****************************************
   // command legality
   // ****************************************
   wire sbt_bank_e tgt = bankState_q[reqBank];
   wire sbt_bank_e lastSt = bankState_q[lastBank_q];
   // a per-bank refresh must not be interrupted, so it blocks every bank
   wire run = devState_q == DEV_RUN && !(|bRef);
   wire allIdle = run && (&bIdle);
   wire tgtOpen = tgt == BS_ACTIVE;
   // bursts must end or be terminated before turning the bus around
   wire okRd = run && (tgtOpen || tgt == BS_READING);
   wire okWr = run && (tgtOpen || tgt == BS_WRITING);
   wire okAct = run && tgt == BS_IDLE;
   wire okPre = run && (tgt == BS_IDLE || tgtOpen);
   wire okPrea = run && (&bIdleAct);
   wire okBst = run && (lastSt == BS_READING || lastSt == BS_WRITING);
   wire okMrr = (run && (&bIdleAct)) || devState_q == DEV_RESETTING;
   wire okReset = devState_q == DEV_POWERON || allIdle;
   // DEV_BUSY accepts nothing but NOP; DEV_RESETTING also accepts MRR
   assign reqReady = reqOp == OP_NOP ? 1'b1 :
                     reqOp == OP_ACT ? okAct :
                     reqOp == OP_RD ? okRd :
                     reqOp == OP_WR ? okWr :
                     reqOp == OP_PRE ? okPre :
                     reqOp == OP_PREA ? okPrea :
                     reqOp == OP_REFPB ? okAct :
                     reqOp == OP_REFAB ? allIdle :
                     reqOp == OP_MRR ? okMrr :
                     reqOp == OP_MRW ? allIdle :
                     reqOp == OP_RESET ? okReset :
                     reqOp == OP_BST ? okBst : 1'b0;
   wire issue = reqValid && reqReady && reqOp != OP_NOP;
   wire bankOp = reqOp == OP_ACT || reqOp == OP_RD || reqOp == OP_WR ||
                 reqOp == OP_PRE || reqOp == OP_REFPB;
   wire devClear = devState_q == DEV_BUSY && devTimer_q == '0 && devClr_q;

   // ****************************************
   // per-bank tracking
   // ****************************************
   for (genvar b = 0; b < NB; b++) begin : g_bank
      assign bIdle[b] = bankState_q[b] == BS_IDLE;
      assign bIdleAct[b] = bIdle[b] || bankState_q[b] == BS_ACTIVE;
      assign bRef[b] = bankState_q[b] == BS_REFRESHING;
      wire hit = issue && bankOp && reqBank == BW'(b);
      wire bstHit = issue && reqOp == OP_BST && lastBank_q == BW'(b);
      always_comb begin
         bankState_d[b] = bankState_q[b];
         bankTimer_d[b] = bankTimer_q[b];
         if (devClear) begin
            bankState_d[b] = BS_IDLE;
            bankTimer_d[b] = '0;
         end else if (hit) begin
            case (reqOp)
               OP_ACT: begin
                  bankState_d[b] = BS_ACTIVATING;
                  bankTimer_d[b] = LD_RCD;
               end
               OP_RD: begin
                  bankState_d[b] = reqAp ? BS_RDAP : BS_READING;
                  bankTimer_d[b] = reqAp ? LD_APB : LD_BURST;
               end
               OP_WR: begin
                  bankState_d[b] = reqAp ? BS_WRAP : BS_WRITING;
                  bankTimer_d[b] = reqAp ? LD_APB : LD_BURST;
               end
               OP_PRE: begin
                  bankState_d[b] = BS_PRECHARGING;
                  bankTimer_d[b] = LD_RP;
               end
               default: begin
                  bankState_d[b] = BS_REFRESHING;
                  bankTimer_d[b] = LD_RFCPB;
               end
            endcase
         end else if (bstHit) begin
            bankState_d[b] = BS_ACTIVE;
            bankTimer_d[b] = '0;
         end else if (bankTimer_q[b] != '0) begin
            bankTimer_d[b] = bankTimer_q[b] - 1'b1;
         end else begin
            bankState_d[b] = settle(bankState_q[b]);
         end
      end
      always_ff @(posedge clk_sys or negedge arst_n) begin
         if (!arst_n) begin
            bankState_q[b] <= BS_IDLE;
            bankTimer_q[b] <= '0;
         end else begin
            bankState_q[b] <= bankState_d[b];
            bankTimer_q[b] <= bankTimer_d[b];
         end
      end
   end

   // ****************************************
   // device-level state
   // ****************************************
   // MR read keeps bank states, so an open bank comes back active
   always_comb begin
      devState_d = devState_q;
      devTimer_d = devTimer_q;
      devClr_d = devClr_q;
      unique case (devState_q)
         DEV_POWERON, DEV_RUN: begin
            if (issue && reqOp == OP_RESET) begin
               devState_d = DEV_RESETTING;
               devTimer_d = LD_INIT;
            end else if (issue && (reqOp == OP_REFAB || reqOp == OP_MRW ||
                                   reqOp == OP_PREA || reqOp == OP_MRR)) begin
               devState_d = DEV_BUSY;
               devClr_d = reqOp != OP_MRR;
               devTimer_d = reqOp == OP_REFAB ? LD_RFCAB :
                            reqOp == OP_MRW ? LD_MRW :
                            reqOp == OP_PREA ? LD_RP : LD_MRR;
            end
         end
         DEV_RESETTING: begin
            if (issue && reqOp == OP_MRR) begin
               devState_d = DEV_BUSY;
               devClr_d = 1'b1;
               devTimer_d = LD_MRR;
            end else if (devTimer_q != '0) begin
               devTimer_d = devTimer_q - 1'b1;
            end else begin
               devState_d = DEV_RUN;
            end
         end
         DEV_BUSY: begin
            if (devTimer_q != '0) begin
               devTimer_d = devTimer_q - 1'b1;
            end else begin
               devState_d = DEV_RUN;
               devClr_d = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         devState_q <= DEV_POWERON;
         devTimer_q <= '0;
         devClr_q <= 1'b0;
      end else begin
         devState_q <= devState_d;
         devTimer_q <= devTimer_d;
         devClr_q <= devClr_d;
      end
   end

   // ****************************************
   // command pins
   // ****************************************
   // clock enable never drops: power-down is not driven by this block
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         memCke_q <= 1'b0;
         memCmd_q <= OP_NOP;
         memBank_q <= '0;
         memAp_q <= 1'b0;
         lastBank_q <= '0;
      end else begin
         memCke_q <= 1'b1;
         memCmd_q <= issue ? reqOp : OP_NOP;
         memBank_q <= reqBank;
         memAp_q <= reqAp;
         if (issue && (reqOp == OP_RD || reqOp == OP_WR)) begin
            lastBank_q <= reqBank;
         end
      end
   end
   assign memCke = memCke_q;
   assign memCmd = memCmd_q;
   assign memBank = memBank_q;
   assign memAp = memAp_q;
   assign devState = devState_q;

   // ****************************************
   // checks
   // ****************************************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   sequence actB0;
      issue && reqOp == OP_ACT && reqBank == '0;
   endsequence
   sequence mrwGo;
      issue && reqOp == OP_MRW;
   endsequence
   sequence allBack;
      devState_q == DEV_RUN && (&bIdle);
   endsequence
   wire tgtBusy = tgt inside {BS_ACTIVATING, BS_PRECHARGING, BS_RDAP, BS_WRAP, BS_REFRESHING};
   busy_nop_a: assert property (devState_q == DEV_BUSY |=> memCmd_q == OP_NOP)
      else $error("command sent while device busy");
   act_time_a: assert property (actB0 |=> bankState_q[0] == BS_ACTIVATING ##A_RCD
      bankState_q[0] == BS_ACTIVE) else $error("activate timing wrong");
   pre_time_a: assert property (issue && reqOp == OP_PRE && reqBank == '0 |->
      ##A_RP bankState_q[0] == BS_PRECHARGING ##1 bankState_q[0] == BS_IDLE)
      else $error("precharge timing wrong");
   wr_turn_a: assert property (issue && reqOp == OP_WR |-> tgt != BS_READING)
      else $error("write during read burst");
   rd_turn_a: assert property (issue && reqOp == OP_RD |-> tgt != BS_WRITING)
      else $error("read during write burst");
   reset_src_a: assert property (memCmd_q == OP_RESET |->
      $past(devState_q) == DEV_POWERON || $past(&bIdle)) else $error("reset not from idle");
   bst_end_a: assert property (issue && reqOp == OP_BST |=>
      bankState_q[$past(lastBank_q)] == BS_ACTIVE) else $error("terminate missed");
   cke_hold_a: assert property (memCke_q |=> memCke_q)
      else $error("clock enable dropped");
   bank_busy_a: assert property (issue && bankOp |-> !tgtBusy)
      else $error("command to busy bank");
   mrw_idle_a: assert property (mrwGo |-> ##A_MRW devState_q == DEV_BUSY ##1 allBack)
      else $error("mode write timing wrong");
   rd_keep_a: assert property (issue && reqOp == OP_RD && !reqAp && tgt == BS_READING &&
      reqBank == '0 |=> bankState_q[0] == BS_READING) else $error("read restart lost");
endmodule
`default_nettype wire

// >>> verif/sbt_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module sbt_mem_model import sbt_pkg::*; #(
   parameter int NB     = 8,
   parameter int BURST  = 4,
   parameter int INIT_P = 8
) (
   input  wire logic                  clk_sys,
   input  wire logic                  arst_n,
   input  wire logic                  memCke,
   input  wire sbt_op_e               memCmd,
   input  wire logic [$clog2(NB)-1:0] memBank,
   input  wire logic                  memAp,
   output logic [15:0]                errCnt
);
   // ****************************************
   // per-bank state plus device state
   // ****************************************
   sbt_bank_e             bs [NB];
   int                    bc [NB];
   sbt_dev_e              dv;
   int                    dc;
   logic                  ckeQ;
   logic [$clog2(NB)-1:0] lastB;

   // timer at zero means the timed state has already ended
   function automatic sbt_bank_e eff(input int b);
      if (bc[b] != 0) return bs[b];
      case (bs[b])
         BS_ACTIVATING, BS_READING, BS_WRITING: return BS_ACTIVE;
         BS_IDLE, BS_ACTIVE: return bs[b];
         default: return BS_IDLE;
      endcase
   endfunction

   function automatic bit allIn(input bit actOk);
      for (int b = 0; b < NB; b++)
         if (!(eff(b) == BS_IDLE || (actOk && eff(b) == BS_ACTIVE))) return 1'b0;
      return 1'b1;
   endfunction

   // ****************************************
   // command tracking and misuse counting
   // ****************************************
   always @(posedge clk_sys or negedge arst_n) begin : step
      sbt_bank_e s;
      sbt_dev_e  d;
      int        bad;
      bit        ai;
      bit        aa;
      bit        rd;
      bit        rf;
      if (!arst_n) begin
         for (int b = 0; b < NB; b++) begin
            bs[b] = BS_IDLE;
            bc[b] = 0;
         end
         dv = DEV_POWERON;
         dc = 0;
         ckeQ = 1'b0;
         lastB = '0;
         errCnt <= 16'h0000;
      end else begin
         bad = 0;
         s = eff(int'(memBank));
         ai = allIn(1'b0);
         aa = allIn(1'b1);
         d = (dc != 0 || dv == DEV_POWERON) ? dv : DEV_RUN;
         rf = 1'b0;
         for (int b = 0; b < NB; b++) begin
            bs[b] = eff(b);
            if (bs[b] == BS_REFRESHING) rf = 1'b1;
            if (bc[b] != 0) bc[b]--;
         end
         dv = d;
         if (dc != 0) dc--;
         if (memCmd != OP_NOP) begin
            if (!memCke || !ckeQ) bad++;
            if (rf) bad++;
            if (!(d == DEV_RUN || (d == DEV_POWERON && memCmd == OP_RESET) ||
                  (d == DEV_RESETTING && memCmd == OP_MRR))) bad++;
            case (memCmd)
               OP_ACT: begin
                  bad += (s != BS_IDLE);
                  bs[memBank] = BS_ACTIVATING;
                  bc[memBank] = RCD_CYC - 1;
               end
               OP_RD, OP_WR: begin
                  rd = (memCmd == OP_RD);
                  bad += !(s == BS_ACTIVE || s == (rd ? BS_READING : BS_WRITING));
                  bs[memBank] = memAp ? (rd ? BS_RDAP : BS_WRAP) : (rd ? BS_READING : BS_WRITING);
                  bc[memBank] = memAp ? BURST + RP_CYC - 1 : BURST - 1;
                  lastB = memBank;
               end
               OP_PRE: begin
                  bad += !(s == BS_IDLE || s == BS_ACTIVE);
                  bs[memBank] = BS_PRECHARGING;
                  bc[memBank] = RP_CYC - 1;
               end
               OP_PREA: begin
                  bad += !aa;
                  dv = DEV_BUSY;
                  dc = RP_CYC - 1;
               end
               OP_REFPB: begin
                  bad += (s != BS_IDLE);
                  bs[memBank] = BS_REFRESHING;
                  bc[memBank] = RFCPB_CYC - 1;
               end
               OP_REFAB, OP_MRW: begin
                  bad += !ai;
                  dv = DEV_BUSY;
                  dc = (memCmd == OP_REFAB ? RFCAB_CYC : MRW_CYC) - 1;
               end
               OP_MRR: begin
                  dv = DEV_BUSY;
                  dc = MRR_CYC - 1;
               end
               OP_BST: begin
                  bad += !(bs[lastB] == BS_READING || bs[lastB] == BS_WRITING);
                  bs[lastB] = BS_ACTIVE;
                  bc[lastB] = 0;
               end
               OP_RESET: begin
                  bad += !ai;
                  dv = DEV_RESETTING;
                  dc = INIT_P - 1;
               end
               default: ;
            endcase
         end
         ckeQ = memCke;
         errCnt <= errCnt + 16'(bad);
      end
   end
endmodule
`default_nettype wire

// >>> verif/sbt_host_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module sbt_host_tb import sbt_pkg::*;;
   localparam int NB    = 8;
   localparam int BURST = 4;
   localparam int LIMIT = 5000;
   logic        clk_sys = 1'b0;
   logic        arst_n, reqValid, reqAp, reqReady, memCke, memAp, expAp, pend;
   sbt_op_e     reqOp, memCmd, expOp;
   logic [2:0]  reqBank, memBank, expBank, b, c;
   sbt_dev_e    devState;
   logic [15:0] errCnt, lfsr;
   int          n_mismatch = 0;
   int          check_count = 0;
   int          cyc = 0;

   always #5 clk_sys = ~clk_sys;

   sbt_host #(.NB(NB), .BURST(BURST), .TW(16), .INIT_CYC_P(8)) i_dut (
      .clk_sys(clk_sys), .arst_n(arst_n), .reqValid(reqValid), .reqOp(reqOp),
      .reqBank(reqBank), .reqAp(reqAp), .reqReady(reqReady), .memCke(memCke),
      .memCmd(memCmd), .memBank(memBank), .memAp(memAp), .devState(devState));
   sbt_mem_model #(.NB(NB), .BURST(BURST), .INIT_P(8)) i_mem (
      .clk_sys(clk_sys), .arst_n(arst_n), .memCke(memCke), .memCmd(memCmd),
      .memBank(memBank), .memAp(memAp), .errCnt(errCnt));

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [15:0] lfsrNext(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // edges from one take to the next when the previous op blocks it
   function automatic int busyGap(input sbt_op_e op);
      case (op)
         OP_ACT: return RCD_CYC + 1;
         OP_PRE, OP_PREA: return RP_CYC + 1;
         OP_REFPB: return RFCPB_CYC + 1;
         OP_REFAB: return RFCAB_CYC + 1;
         OP_MRR: return MRR_CYC + 1;
         OP_MRW: return MRW_CYC + 1;
         default: return 1;
      endcase
   endfunction

   task automatic close_out;
      if (n_mismatch == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // request held until taken; entered and left at a take edge
   task automatic issue(input sbt_op_e op, input logic [2:0] bk, input logic ap, input int gap);
      int   d;
      logic rdy;
      d = 0;
      reqValid <= 1'b1;
      reqOp <= op;
      reqBank <= bk;
      reqAp <= ap;
      do begin
         @(negedge clk_sys);
         rdy = reqReady;
         @(posedge clk_sys);
         d++;
      end while (rdy !== 1'b1 && d < 400);
      expOp = op;
      expBank = bk;
      expAp = ap;
      pend = 1'b1;
      if (gap >= 0) `CHK("gap", gap, d)
   endtask

   always @(negedge clk_sys) if (pend) begin
      pend = 1'b0;
      `CHK("memCmd", expOp, memCmd)
      `CHK("memBank", expBank, memBank)
      `CHK("memAp", expAp, memAp)
      if (expOp == OP_MRW) `CHK("devState", DEV_BUSY, devState)
      if (expOp == OP_RESET) `CHK("devState", DEV_RESETTING, devState)
   end

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == LIMIT) begin
         n_mismatch++;
         close_out();
      end
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      arst_n = 1'b0;
      reqValid = 1'b0;
      reqOp = OP_NOP;
      reqBank = 3'h0;
      reqAp = 1'b0;
      pend = 1'b0;
      lfsr = 16'hE68D;
      @(posedge clk_sys);
      @(negedge clk_sys);
      `CHK("memCke", 1'b0, memCke)
      `CHK("memCmd", OP_NOP, memCmd)
      `CHK("devState", DEV_POWERON, devState)
      @(posedge clk_sys) arst_n <= 1'b1;
      @(posedge clk_sys);
      @(negedge clk_sys);
      `CHK("memCke", 1'b1, memCke)
      for (int i = 0; i < 12; i++) begin
         @(posedge clk_sys) reqOp <= sbt_op_e'(i);
         @(negedge clk_sys);
         `CHK("reqReady", 1'(i == OP_RESET || i == OP_NOP), reqReady)
      end
      @(posedge clk_sys);
      issue(OP_RESET, 3'h0, 1'b0, -1);
      issue(OP_MRR, 3'h0, 1'b0, 1);
      for (int it = 0; it < 8; it++) begin
         lfsr = lfsrNext(lfsr);
         b = it == 0 ? 3'h0 : lfsr[2:0];
         c = b ^ 3'h1;
         issue(OP_ACT, b, lfsr[3], it == 0 ? -1 : busyGap(OP_MRW));
         issue(OP_ACT, c, lfsr[4], 1);
         issue(OP_RD, b, 1'b0, RCD_CYC);
         issue(OP_RD, b, 1'b0, 1);
         issue(OP_WR, b, 1'b0, BURST + 1);
         issue(OP_WR, b, 1'b0, 1);
         issue(OP_BST, c, lfsr[5], 1);
         issue(it[0] ? OP_WR : OP_RD, c, 1'b1, 1);
         issue(OP_PRE, b, lfsr[6], 1);
         issue(OP_ACT, c, lfsr[7], BURST + RP_CYC);
         issue(OP_PRE, c, lfsr[8], busyGap(OP_ACT));
         issue(OP_PREA, b, lfsr[9], busyGap(OP_PRE));
         issue(OP_REFPB, c, lfsr[10], busyGap(OP_PREA));
         issue(OP_REFAB, b, lfsr[11], busyGap(OP_REFPB));
         issue(OP_MRR, b, lfsr[12], busyGap(OP_REFAB));
         issue(OP_MRW, b, lfsr[13], busyGap(OP_MRR));
      end
      reqValid <= 1'b0;
      reqOp <= OP_NOP;
      repeat (10) @(posedge clk_sys);
      `CHK("errCnt", 16'h0000, errCnt)
      close_out();
   end
endmodule
`undef CHK
`default_nettype wire
